// >>> logic/adr_regs.svh
`ifndef ADR_REGS_SVH
`define ADR_REGS_SVH

// ****************************************************************
// register offsets (byte addresses on apb)
// ****************************************************************
`define ADR_OFF_CTRL 12'h000
`define ADR_OFF_STAT 12'h004
`define ADR_OFF_INT_STAT 12'h008
`define ADR_OFF_INT_MASK 12'h00c
`define ADR_OFF_RSP_CNT 12'h010

// ****************************************************************
// control register fields
// ****************************************************************
`define ADR_CTRL_ENABLE 0
`define ADR_CTRL_ENH_LONG 1
`define ADR_CTRL_ENH_SHORT 2
`define ADR_CTRL_ADDR_LO 4
`define ADR_CTRL_ADDR_HI 7
`define ADR_CTRL_ATTR_LO 8
`define ADR_CTRL_ATTR_HI 9
`define ADR_CTRL_RST 10'h001

// ****************************************************************
// status register fields
// ****************************************************************
`define ADR_STAT_FAULT 10
`define ADR_STAT_SELF_TEST 11

// ****************************************************************
// interrupt bits
// ****************************************************************
`define ADR_INT_RSP_SENT 0
`define ADR_INT_IGN_GLOBAL 1
`define ADR_INT_IGN_UNIMPL 2
`define ADR_INT_SENSOR_ERR 3
`define ADR_INT_W 4
`define ADR_INT_RST 4'h0

// ****************************************************************
// command codes, addresses, lengths, codes
// ****************************************************************
`define ADR_CMD_ACCEL 4'h2
`define ADR_CMD_UNIMPL 4'h3
`define ADR_GLOBAL_ADDR 4'h0
`define ADR_LEN_MIN 5'h08
`define ADR_LEN_9 5'h09
`define ADR_LEN_11 5'h0b
`define ADR_LEN_13 5'h0d
`define ADR_LEN_14 5'h0e
`define ADR_LEN_15 5'h0f
`define ADR_LEN_LONG 5'h10
`define ADR_CODE_MIN 10'h001
`define ADR_CODE_ERR 10'h000

`endif

// >>> logic/adr_pkg.sv
`include "adr_regs.svh"

package adr_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [3:0] adr_nib_t;
  typedef logic [4:0] adr_len_t;
  typedef logic [9:0] adr_code_t;
  typedef logic [15:0] adr_rsp_t;
  typedef logic [`ADR_INT_W-1:0] adr_int_t;

  typedef enum logic [3:0] {
    ADR_CMD_ACCEL_E = `ADR_CMD_ACCEL,
    ADR_CMD_UNIMPL_E = `ADR_CMD_UNIMPL
  } adr_cmd_t;

endpackage : adr_pkg

// >>> logic/adr_rsp_build.sv
`include "adr_regs.svh"

// response word builder for the acceleration read answer
module adr_rsp_build (
  input wire adr_pkg::adr_code_t i_code,
  input wire adr_pkg::adr_len_t i_len,
  input wire logic i_long,
  input wire adr_pkg::adr_nib_t i_addr,
  input wire logic i_fault,
  input wire logic i_self_test,
  input wire logic [1:0] i_attr,
  output logic [15:0] o_data
);
  import adr_pkg::*;

  // ****************************************************************
  // truncated codes, zero replaced by the minimum code
  // ****************************************************************
  logic [7:0] tr8;
  logic [8:0] tr9;
  logic [7:0] tr8_fix;
  logic [8:0] tr9_fix;
  assign tr8 = i_code[9:2];
  assign tr9 = i_code[9:1];
  assign tr8_fix = (tr8 == 8'h00) ? 8'h01 : tr8;
  assign tr9_fix = (tr9 == 9'h000) ? 9'h001 : tr9;

  // ****************************************************************
  // short word with status fields up to bit 14
  // ****************************************************************
  logic [15:0] full_short;
  logic [15:0] len_mask;
  logic [15:0] short_word;
  assign full_short = {1'b0, i_attr[1], i_attr[0], i_self_test, 1'b0,
                       i_fault, i_code};

  // keep only bits below the message length
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_mask
      assign len_mask[gi] = (5'(gi) < i_len);
    end
  endgenerate

  assign short_word = (i_len == `ADR_LEN_MIN) ? {8'h00, tr8_fix} :
                      (i_len == `ADR_LEN_9) ? {7'h00, tr9_fix} :
                      (full_short & len_mask);

  // ****************************************************************
  // final selection
  // ****************************************************************
  assign o_data = i_long ? {i_addr, 1'b0, i_fault, i_code}
                         : short_word;

endmodule : adr_rsp_build

// >>> logic/adr_top.sv
`include "adr_regs.svh"

module adr_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // decoded incoming message from the link layer
  input wire logic i_msg_valid,
  input wire logic i_msg_crc_ok,
  input wire logic i_msg_long,
  input wire logic i_msg_enh,
  input wire adr_pkg::adr_len_t i_msg_len,
  input wire adr_pkg::adr_nib_t i_msg_addr,
  input wire adr_pkg::adr_nib_t i_msg_cmd,
  input wire logic [7:0] i_msg_data,
  // sensor side
  input wire adr_pkg::adr_code_t i_accel,
  input wire logic i_int_fault,
  input wire logic i_self_test,
  // response to the link layer
  output logic o_rsp_valid,
  output adr_pkg::adr_rsp_t o_rsp_data,
  output adr_pkg::adr_len_t o_rsp_len,
  // interrupt
  output logic o_irq
);
  import adr_pkg::*;

  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n;

  // async assert, sync release
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [9:0] ctrl_q;
  logic [9:0] ctrl_d;
  adr_int_t int_stat_q;
  adr_int_t int_stat_d;
  adr_int_t int_mask_q;
  adr_int_t int_mask_d;
  logic [15:0] rsp_cnt_q;
  logic [15:0] rsp_cnt_d;
  adr_code_t last_code_q;
  adr_code_t last_code_d;

  // control fields
  logic ctl_enable;
  logic ctl_enh_long;
  logic ctl_enh_short;
  adr_nib_t programmed_bus_address;
  logic [1:0] attribute_bits;
  assign ctl_enable = ctrl_q[`ADR_CTRL_ENABLE];
  assign ctl_enh_long = ctrl_q[`ADR_CTRL_ENH_LONG];
  assign ctl_enh_short = ctrl_q[`ADR_CTRL_ENH_SHORT];
  assign programmed_bus_address =
    ctrl_q[`ADR_CTRL_ADDR_HI:`ADR_CTRL_ADDR_LO];
  // device_config_one attribute field
  assign attribute_bits = ctrl_q[`ADR_CTRL_ATTR_HI:`ADR_CTRL_ATTR_LO];

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic is_accel;
  logic is_unimpl;
  logic addr_match;
  logic addr_global;
  logic fmt_ok;
  logic len_ok;
  logic msg_ok;
  logic accept;
  logic ign_global;
  logic ign_unimpl;

  // the data byte is covered by the crc check upstream only
  assign msg_ok = i_msg_valid & i_msg_crc_ok & ctl_enable;
  assign is_accel = (i_msg_cmd == ADR_CMD_ACCEL_E);
  assign is_unimpl = (i_msg_cmd == ADR_CMD_UNIMPL_E);
  assign addr_match = (i_msg_addr == programmed_bus_address);
  assign addr_global = (programmed_bus_address == `ADR_GLOBAL_ADDR);

  // enhanced formats only as enabled by the format setup
  assign fmt_ok = !i_msg_enh | (i_msg_long ? ctl_enh_long
                                           : ctl_enh_short);

  // short length window, long always 16 bits
  assign len_ok = i_msg_long |
                  ((i_msg_len >= `ADR_LEN_MIN) &&
                   (i_msg_len <= `ADR_LEN_15));

  assign accept = msg_ok & is_accel & addr_match & !addr_global &
                  fmt_ok & len_ok;
  assign ign_global = msg_ok & is_accel & addr_global;
  assign ign_unimpl = msg_ok & is_unimpl;

  // ****************************************************************
  // response word
  // ****************************************************************
  logic [15:0] rsp_word;
  adr_len_t rsp_len;
  assign rsp_len = i_msg_long ? `ADR_LEN_LONG : i_msg_len;

  // offset binary code taken as is, all ones max positive
  adr_rsp_build u_build (
    .i_code(i_accel),
    .i_len(rsp_len),
    .i_long(i_msg_long),
    .i_addr(programmed_bus_address),
    .i_fault(i_int_fault),
    .i_self_test(i_self_test),
    .i_attr(attribute_bits),
    .o_data(rsp_word)
  );

  // zero code is the sensor error marker
  logic sensor_err;
  assign sensor_err = accept & (i_accel == `ADR_CODE_ERR);

  // ****************************************************************
  // response output registers
  // ****************************************************************
  logic rsp_valid_q;
  adr_rsp_t rsp_data_q;
  adr_len_t rsp_len_q;

  // one cycle after the message, only for accepted commands
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      rsp_len_q <= 5'h00;
    end else begin
      rsp_valid_q <= accept;
      if (accept) begin
        rsp_data_q <= rsp_word;
        rsp_len_q <= rsp_len;
      end
    end
  end

  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_rsp_len = rsp_len_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup;
  logic wr_en;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_istat;
  logic sel_imask;
  logic sel_cnt;
  logic mapped;
  assign setup = i_psel & !i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign sel_ctrl = (i_paddr == `ADR_OFF_CTRL);
  assign sel_stat = (i_paddr == `ADR_OFF_STAT);
  assign sel_istat = (i_paddr == `ADR_OFF_INT_STAT);
  assign sel_imask = (i_paddr == `ADR_OFF_INT_MASK);
  assign sel_cnt = (i_paddr == `ADR_OFF_RSP_CNT);
  assign mapped = sel_ctrl | sel_stat | sel_istat | sel_imask | sel_cnt;

  // zero wait states
  assign o_pready = 1'b1;

  // ****************************************************************
  // read data mux, captured in the setup cycle
  // ****************************************************************
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  assign stat_word = {20'h00000, i_self_test, i_int_fault, last_code_q};
  assign rd_mux = sel_ctrl ? {22'h000000, ctrl_q} :
                  sel_stat ? stat_word :
                  sel_istat ? {28'h0000000, int_stat_q} :
                  sel_imask ? {28'h0000000, int_mask_q} :
                  sel_cnt ? {16'h0000, rsp_cnt_q} : 32'h00000000;

  logic [31:0] prdata_q;
  logic pslverr_q;

  // read data and error answer held for the access phase
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= i_pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= !mapped;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

  // ****************************************************************
  // register next values
  // ****************************************************************
  adr_int_t int_set;
  adr_int_t int_clr;
  assign int_set[`ADR_INT_RSP_SENT] = accept;
  assign int_set[`ADR_INT_IGN_GLOBAL] = ign_global;
  assign int_set[`ADR_INT_IGN_UNIMPL] = ign_unimpl;
  assign int_set[`ADR_INT_SENSOR_ERR] = sensor_err;
  assign int_clr = (wr_en & sel_istat) ? i_pwdata[`ADR_INT_W-1:0]
                                       : `ADR_INT_RST;

  // set wins over a same-cycle write-one clear
  assign int_stat_d = (int_stat_q & ~int_clr) | int_set;
  assign int_mask_d = (wr_en & sel_imask) ? i_pwdata[`ADR_INT_W-1:0]
                                          : int_mask_q;
  assign ctrl_d = (wr_en & sel_ctrl) ? i_pwdata[9:0] : ctrl_q;
  assign rsp_cnt_d = accept ? rsp_cnt_q + 16'h0001 : rsp_cnt_q;
  assign last_code_d = accept ? i_accel : last_code_q;

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ADR_CTRL_RST;
      int_stat_q <= `ADR_INT_RST;
      int_mask_q <= `ADR_INT_RST;
      rsp_cnt_q <= 16'h0000;
      last_code_q <= `ADR_CODE_ERR;
    end else begin
      ctrl_q <= ctrl_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      rsp_cnt_q <= rsp_cnt_d;
      last_code_q <= last_code_d;
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  logic irq_q;

  // level high while any unmasked status bit is set
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_stat_d & int_mask_d);
    end
  end

  assign o_irq = irq_q;

endmodule : adr_top

// >>> tb/adr_assertions.sv
`include "adr_regs.svh"

module adr_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_msg_valid,
  input wire logic i_msg_long,
  input wire adr_pkg::adr_len_t i_msg_len,
  input wire adr_pkg::adr_nib_t i_msg_addr,
  input wire adr_pkg::adr_nib_t i_msg_cmd,
  input wire adr_pkg::adr_code_t i_accel,
  input wire logic i_int_fault,
  input wire logic i_self_test,
  input wire logic o_rsp_valid,
  input wire adr_pkg::adr_rsp_t o_rsp_data,
  input wire adr_pkg::adr_len_t o_rsp_len,
  input wire logic o_irq
);
  import adr_pkg::*;
  // ****************************************************************
  // answer checks, one cycle after the taking edge
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  glob_silent_a: assert property (i_msg_valid &&
    i_msg_addr == `ADR_GLOBAL_ADDR |=> !o_rsp_valid)
    else $error("answer to global address");
  unimpl_silent_a: assert property (i_msg_valid &&
    i_msg_cmd == `ADR_CMD_UNIMPL |=> !o_rsp_valid)
    else $error("answer to unimplemented command");
  no_cmd_silent_a: assert property (!i_msg_valid |=>
    !o_rsp_valid) else $error("answer without command");
  long_fmt_a: assert property (o_rsp_valid && $past(i_msg_long)
    |-> o_rsp_len == 5'h10 && o_rsp_data == {$past(i_msg_addr),
    1'b0, $past(i_int_fault), $past(i_accel)})
    else $error("long answer layout wrong");
  short_len_a: assert property (o_rsp_valid &&
    !$past(i_msg_long) |-> o_rsp_len == $past(i_msg_len))
    else $error("answer length differs");
  full_res_a: assert property (o_rsp_valid &&
    o_rsp_len >= 5'h0a |-> o_rsp_data[9:0] == $past(i_accel))
    else $error("result field wrong");
  trunc9_a: assert property (o_rsp_valid && o_rsp_len == 5'h09
    |-> o_rsp_data == (($past(i_accel[9:1]) == 9'h0) ? 16'h0001
    : {7'h0, $past(i_accel[9:1])})) else $error("nine bit code wrong");
  trunc8_a: assert property (o_rsp_valid && o_rsp_len == 5'h08
    |-> o_rsp_data[7:0] == (($past(i_accel[9:2]) == 8'h0) ? 8'h01
    : $past(i_accel[9:2]))) else $error("eight bit code wrong");
  fault_bit_a: assert property (o_rsp_valid &&
    o_rsp_len >= 5'h0b |-> o_rsp_data[10] == $past(i_int_fault))
    else $error("fault flag wrong");
  st_bit_a: assert property (o_rsp_valid && !$past(i_msg_long)
    && o_rsp_len >= 5'h0d |-> o_rsp_data[12] == $past(i_self_test))
    else $error("self test flag wrong");
  pad_zero_a: assert property (o_rsp_valid &&
    o_rsp_len < 5'h10 |-> (o_rsp_data >> o_rsp_len) == 16'h0)
    else $error("padding not zero");
  // main scenarios
  cover property (o_rsp_valid && o_rsp_len == 5'h10);
  cover property (o_rsp_valid && o_rsp_len == 5'h08);
  cover property ($rose(o_irq));
endmodule : adr_checker

bind adr_top adr_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_msg_valid(i_msg_valid), .i_msg_long(i_msg_long),
  .i_msg_len(i_msg_len), .i_msg_addr(i_msg_addr), .i_msg_cmd(i_msg_cmd),
  .i_accel(i_accel), .i_int_fault(i_int_fault),
  .i_self_test(i_self_test), .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data), .o_rsp_len(o_rsp_len), .o_irq(o_irq));

// >>> tb/adr_bus_master.sv
module adr_bus_master (
  input wire logic i_clk,
  output logic o_valid,
  output logic o_crc_ok,
  output logic o_long,
  output logic o_enh,
  output adr_pkg::adr_len_t o_len,
  output adr_pkg::adr_nib_t o_addr,
  output adr_pkg::adr_nib_t o_cmd,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  // idle: no frame, fields hold junk
  initial begin
    o_valid = 1'b0;
    o_crc_ok = 1'b0;
    {o_long, o_enh, o_len, o_addr, o_cmd, o_data} = 23'h5a5a5a;
  end
  // one decoded message, one cycle, then fields scrambled
  task automatic send(input logic lg, input logic en, input adr_len_t ln,
    input adr_nib_t ad, input adr_nib_t cm);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_crc_ok <= 1'b1;
    o_long <= lg;
    o_enh <= en;
    o_len <= ln;
    o_addr <= ad;
    o_cmd <= cm;
    o_data <= 8'($urandom);
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_crc_ok <= 1'($urandom);
    o_addr <= ~ad;
    o_cmd <= ~cm;
    o_len <= ~ln;
    o_data <= ~o_data;
  endtask : send
endmodule : adr_bus_master

// >>> tb/testbench.sv
`include "adr_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic fault = 0, self_t = 0, pready, pslverr, rsp_valid, irq;
  logic m_valid, m_crc, m_long, m_enh;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  adr_code_t accel = 10'h0;
  adr_len_t m_len, rsp_len, ln;
  adr_nib_t m_addr, m_cmd;
  logic [7:0] m_data;
  adr_rsp_t rsp_data;
  int err_count = 0, cmp_count = 0, n_ans = 0;
  logic e;
  // enhanced formats allowed per kind (long, short); force enhanced
  logic [1:0] enh_on = 2'b11;
  logic enh_force = 1'b0;
  adr_code_t corner [8] = '{10'h0, 10'h1, 10'h3ff, 10'h200, 10'h0,
    10'h1, 10'h3ff, 10'h2ff};

  adr_top u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_msg_valid(m_valid), .i_msg_crc_ok(m_crc),
    .i_msg_long(m_long), .i_msg_enh(m_enh), .i_msg_len(m_len),
    .i_msg_addr(m_addr), .i_msg_cmd(m_cmd), .i_msg_data(m_data),
    .i_accel(accel), .i_int_fault(fault), .i_self_test(self_t),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_len(rsp_len), .o_irq(irq));
  adr_bus_master u_mst (.i_clk(clk), .o_valid(m_valid), .o_crc_ok(m_crc),
    .o_long(m_long), .o_enh(m_enh), .o_len(m_len), .o_addr(m_addr),
    .o_cmd(m_cmd), .o_data(m_data));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expected answer word worked out from the field layout
  function automatic adr_rsp_t exp_rsp(logic lg, adr_len_t n,
    adr_code_t ac, logic f, logic st);
    adr_rsp_t v;
    v = {3'b010, st, 1'b0, f, ac} & ((16'h1 << n) - 16'h1);
    if (lg) v = {4'h5, 1'b0, f, ac};
    else if (n == 5'h08) v = (ac[9:2] == 0) ? 16'h1 : {8'h0, ac[9:2]};
    else if (n == 5'h09) v = (ac[9:1] == 0) ? 16'h1 : {7'h0, ac[9:1]};
    return v;
  endfunction : exp_rsp

  task automatic msg(input logic lg, input adr_len_t n,
    input adr_nib_t ad, input adr_nib_t cm, input logic ans,
    input adr_code_t ac);
    logic f, st, en, ok;
    f = 1'($urandom);
    st = 1'($urandom);
    en = enh_force | 1'($urandom);
    ok = ans && (!en || (lg ? enh_on[1] : enh_on[0]));
    @(posedge clk);
    {accel, fault, self_t} <= {ac, f, st};
    u_mst.send(lg, en, n, ad, cm);
    @(negedge clk);
    chk("rsp_valid", rsp_valid, ok);
    if (ok) begin
      n_ans++;
      chk("rsp_data", rsp_data, exp_rsp(lg, n, ac, f, st));
      chk("rsp_len", rsp_len, lg ? 5'h10 : n);
    end
  endtask : msg

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(49262));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, `ADR_OFF_CTRL, 0);
    chk("ctrl_rst", q, 32'h1);
    apb(0, `ADR_OFF_INT_MASK, 0);
    chk("mask_rst", q, 32'h0);
    apb(0, 12'h020, 0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1, `ADR_OFF_CTRL, 32'h257);
    apb(1, `ADR_OFF_INT_MASK, 32'h1);
    $display("registers done");
    for (int i = 0; i < 48; i++) begin
      ln = (i < 8) ? 5'(8 + i) : 5'(8 + $urandom % 8);
      msg(i > 8 && 1'($urandom), ln, 4'h5, `ADR_CMD_ACCEL, 1'b1,
        (i < 8) ? corner[i] : 10'($urandom));
    end
    apb(0, `ADR_OFF_STAT, 0);
    chk("stat_word", q[11:0], {self_t, fault, accel});
    msg(1'b1, 5'h0, 4'h5, `ADR_CMD_ACCEL, 1'b1, 10'h0);
    $display("answers done");
    chk("irq_set", irq, 1'b1);
    apb(0, `ADR_OFF_INT_STAT, 0);
    chk("stat_sent", q[0], 1'b1);
    apb(1, `ADR_OFF_INT_STAT, 32'hf);
    @(negedge clk);
    chk("irq_clr", irq, 1'b0);
    msg(1'b0, 5'h0a, 4'h6, `ADR_CMD_ACCEL, 1'b0, 10'h123);
    msg(1'b0, 5'h0a, 4'h5, `ADR_CMD_UNIMPL, 1'b0, 10'h123);
    msg(1'b1, 5'h0, 4'h5, 4'h1, 1'b0, 10'h123);
    chk("irq_masked", irq, 1'b0);
    apb(0, `ADR_OFF_INT_STAT, 0);
    chk("stat_unimpl", q[2:0], 3'h4);
    apb(0, `ADR_OFF_RSP_CNT, 0);
    chk("rsp_cnt", q[15:0], 16'(n_ans));
    // enhanced long allowed, enhanced short refused
    apb(1, `ADR_OFF_CTRL, 32'h253);
    {enh_on, enh_force} = 3'b101;
    for (int i = 0; i < 4; i++) begin
      msg(1'(i), 5'h0c, 4'h5, `ADR_CMD_ACCEL, 1'b1, 10'($urandom));
    end
    enh_force = 1'b0;
    enh_on = 2'b11;
    $display("formats done");
    apb(1, `ADR_OFF_CTRL, 32'h207);
    msg(1'b0, 5'h0a, 4'h0, `ADR_CMD_ACCEL, 1'b0, 10'h200);
    apb(0, `ADR_OFF_INT_STAT, 0);
    chk("stat_glob", q[1], 1'b1);
    $display("ignores done");
    wrap_up();
  end
endmodule : testbench
